// *** inc/dma_copy_defines.svh ***
// Register offsets, field positions, reset values and timing counts for the buffer DMA
`ifndef DMA_COPY_DEFINES_SVH
`define DMA_COPY_DEFINES_SVH

`define ADDR_W 5
`define PTR_W 13
`define PTR_MAX 13'h1FFF
`define OFF_IRQ_ENABLE 5'h00
`define OFF_IRQ_FLAG 5'h01
`define OFF_CONTROL_ONE 5'h02
`define OFF_RXEND_L 5'h03
`define OFF_RXEND_H 5'h04
`define OFF_RXSTART_L 5'h05
`define OFF_RXSTART_H 5'h06
`define OFF_SRCSTART_L 5'h07
`define OFF_SRCSTART_H 5'h08
`define OFF_SRCEND_L 5'h09
`define OFF_SRCEND_H 5'h0A
`define OFF_DST_L 5'h0B
`define OFF_DST_H 5'h0C
`define OFF_CSUM_L 5'h0D
`define OFF_CSUM_H 5'h0E
`define BIT_GLOBAL_IE 7
`define BIT_DMA_IE 5
`define BIT_DMA_IF 5
`define BIT_GO_BUSY 5
`define BIT_CSUM_SEL 4
`define BIT_TX_REQ 3
`define RST_BYTE 8'h00
`define RST_PTR 13'h0000
`define RST_CSUM 16'h0000
`define COPY_CYCLES_PER_BYTE 2
`define CSUM_CYCLES_PER_BYTE 1

`endif

// *** inc/dma_copy_pkg.sv ***
// Types shared by the buffer DMA engine
package dma_copy_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT_TX = 2'b01,
        ST_READ = 2'b11,
        ST_WRITE = 2'b10
    } dma_state_type;
endpackage

// *** logic/csum_accum.sv ***
// One's-complement checksum accumulator fed one byte at a time, big-endian pairing
module csum_accum
    import dma_copy_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic byte_valid,
    input wire logic [7:0] byte_in,
    output logic [15:0] result
);
    logic [15:0] sum;
    logic odd_half;
    logic [7:0] high_byte;

    // End-around carry addition
    function automatic logic [15:0] ones_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[15:0] + {15'h0000, s[16]};
    endfunction

    // Even bytes are held as the high half; odd bytes complete the word
    always_ff @(posedge clk)
    begin
        if (rst || clear)
        begin
            sum <= 16'h0000;
            odd_half <= 1'b0;
            high_byte <= 8'h00;
        end
        else if (byte_valid)
        begin
            if (odd_half)
                sum <= ones_add(sum, {high_byte, byte_in});
            else
                high_byte <= byte_in;
            odd_half <= ~odd_half;
        end
    end

    // Result already folds in a byte arriving this cycle, so completion can latch it
    // directly; a pending high byte pairs with a 00 pad, and the sum is complemented
    always_comb
    begin
        if (odd_half)
            result = ~ones_add(sum, {high_byte, byte_valid ? byte_in : 8'h00});
        else if (byte_valid)
            result = ~ones_add(sum, {byte_in, 8'h00});
        else
            result = ~sum;
    end
endmodule

// *** logic/pointer_step.sv ***
// Next-address logic for the circular source pointer and linear destination
module pointer_step
    import dma_copy_pkg::*;
(
    input wire logic [12:0] src,
    input wire logic [12:0] dst,
    input wire logic [12:0] rx_start,
    input wire logic [12:0] rx_end,
    output logic [12:0] next_src,
    output logic [12:0] next_dst
);
    // Source follows the receive ring; destination only wraps at top of buffer
    always_comb
    begin
        if (src == rx_end)
            next_src = rx_start;
        else
            next_src = src + 13'h0001;
        next_dst = dst + 13'h0001;
    end
endmodule

// *** logic/buffer_dma_copy_checksum.sv ***
// Buffer DMA engine: copy and checksum over the 8-Kbyte packet buffer
//
// The register offsets and strobed register access are this design's own decisions.
module buffer_dma_copy_checksum
    import dma_copy_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [4:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic TX_REQUEST_ACTIVE,
    output logic [12:0] MEM_ADDR,
    output logic MEM_RD,
    output logic MEM_WR,
    output logic [7:0] MEM_WDATA,
    input wire logic [7:0] MEM_RDATA,
    output logic INT_N
);
`include "dma_copy_defines.svh"

    logic global_irq_enable;
    logic dma_done_irq_enable;
    logic [7:0] irq_enable_other;
    logic dma_done_flag;
    logic [7:0] irq_flag_other;
    logic dma_go_busy;
    logic checksum_select;
    logic [7:0] control_other;
    logic [12:0] rx_buffer_end;
    logic [12:0] rx_buffer_start;
    logic [12:0] dma_source_start;
    logic [12:0] dma_source_end;
    logic [12:0] dma_dest_start;
    logic [15:0] dma_checksum_result;
    dma_state_type state;
    logic [12:0] src_ptr;
    logic [12:0] dst_ptr;
    logic [12:0] next_src;
    logic [12:0] next_dst;
    logic first_byte;
    logic [15:0] csum_value;
    logic csum_byte_valid;
    logic csum_clear;
    logic byte_done;
    logic last_byte;
    logic finish;
    logic go_write;
    logic go_clear;

    // Merge a low or high pointer byte; high byte keeps five bits only
    function automatic logic [12:0] put_byte(input logic [12:0] p, input logic [7:0] d,
                                             input logic high);
        if (high)
            return {d[4:0], p[7:0]};
        else
            return {p[12:8], d};
    endfunction

    // Decode of control writes that touch the go/busy bit
    assign go_write = WR && (ADDR == `OFF_CONTROL_ONE);
    assign go_clear = go_write && !WDATA[`BIT_GO_BUSY];

    pointer_step u_step (
        .src(src_ptr),
        .dst(dst_ptr),
        .rx_start(rx_buffer_start),
        .rx_end(rx_buffer_end),
        .next_src(next_src),
        .next_dst(next_dst)
    );

    csum_accum u_csum (
        .clk(CLK),
        .rst(RST),
        .clear(csum_clear),
        .byte_valid(csum_byte_valid),
        .byte_in(MEM_RDATA),
        .result(csum_value)
    );

    // A byte completes on each checksum read or each copy write
    assign csum_byte_valid = (state == ST_READ) && checksum_select;
    assign byte_done = csum_byte_valid || (state == ST_WRITE);
    // End test after the byte, before stepping; the first byte never ends a run,
    // so equal start and end sweeps the whole receive ring instead of moving one byte
    assign last_byte = byte_done && !first_byte && (src_ptr == dma_source_end);
    assign finish = last_byte && !go_clear;
    assign csum_clear = (state == ST_IDLE);

    // Engine sequencing; abort by clearing go/busy drops straight to idle
    always_ff @(posedge CLK)
    begin
        if (RST)
            state <= ST_IDLE;
        else if (go_clear || !dma_go_busy)
            state <= ST_IDLE;
        else
        begin
            unique case (state)
                ST_IDLE:
                    state <= ST_WAIT_TX;
                ST_WAIT_TX:
                    if (checksum_select || !TX_REQUEST_ACTIVE)
                        state <= ST_READ;
                ST_READ:
                    if (checksum_select)
                        state <= last_byte ? ST_IDLE : ST_READ;
                    else
                        state <= ST_WRITE;
                ST_WRITE:
                    state <= last_byte ? ST_IDLE : ST_READ;
            endcase
        end
    end

    // Internal source and destination pointers
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            src_ptr <= `RST_PTR;
            dst_ptr <= `RST_PTR;
        end
        else if (state == ST_IDLE)
        begin
            src_ptr <= dma_source_start;
            dst_ptr <= dma_dest_start;
        end
        else if (byte_done)
        begin
            src_ptr <= next_src;
            if (state == ST_WRITE)
                dst_ptr <= next_dst;
        end
    end

    // Marks the first byte of a run; cleared once that byte is done
    always_ff @(posedge CLK)
    begin
        if (RST)
            first_byte <= 1'b1;
        else if (state == ST_IDLE)
            first_byte <= 1'b1;
        else if (byte_done)
            first_byte <= 1'b0;
    end

    // Memory port; checksum mode never issues a write
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            MEM_ADDR <= `RST_PTR;
            MEM_RD <= 1'b0;
            MEM_WR <= 1'b0;
            MEM_WDATA <= 8'h00;
        end
        else
        begin
            MEM_RD <= 1'b0;
            MEM_WR <= 1'b0;
            // Present the address of the byte the next read cycle fetches; the
            // one port alternates fetch and store, never both in one cycle
            MEM_ADDR <= byte_done ? next_src : src_ptr;
            // A copy read launches the store of that byte in the write cycle
            if (state == ST_READ && !go_clear && !checksum_select)
            begin
                MEM_ADDR <= dst_ptr;
                MEM_WDATA <= MEM_RDATA;
                MEM_WR <= 1'b1;
            end
        end
    end

    // Go/busy and mode select; hardware clear on completion
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            dma_go_busy <= 1'b0;
            checksum_select <= 1'b0;
            control_other <= `RST_BYTE;
        end
        else
        begin
            if (go_write)
            begin
                dma_go_busy <= WDATA[`BIT_GO_BUSY];
                checksum_select <= WDATA[`BIT_CSUM_SEL];
                control_other <= WDATA;
            end
            if (finish)
                dma_go_busy <= 1'b0;
        end
    end

    // Done flag: set on finish or abort; set wins over host clear
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            dma_done_flag <= 1'b0;
            irq_flag_other <= `RST_BYTE;
        end
        else
        begin
            if (WR && ADDR == `OFF_IRQ_FLAG)
            begin
                dma_done_flag <= WDATA[`BIT_DMA_IF];
                irq_flag_other <= WDATA;
            end
            if (finish || (go_clear && dma_go_busy))
                dma_done_flag <= 1'b1;
        end
    end

    // Checksum result only updated at checksum completion
    always_ff @(posedge CLK)
    begin
        if (RST)
            dma_checksum_result <= `RST_CSUM;
        else if (finish && checksum_select)
            dma_checksum_result <= csum_value;
    end

    // Software-written pointers and enables; frozen by convention while busy
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            global_irq_enable <= 1'b0;
            dma_done_irq_enable <= 1'b0;
            irq_enable_other <= `RST_BYTE;
            rx_buffer_end <= `RST_PTR;
            rx_buffer_start <= `RST_PTR;
            dma_source_start <= `RST_PTR;
            dma_source_end <= `RST_PTR;
            dma_dest_start <= `RST_PTR;
        end
        else if (WR)
        begin
            unique case (ADDR)
                `OFF_IRQ_ENABLE:
                begin
                    global_irq_enable <= WDATA[`BIT_GLOBAL_IE];
                    dma_done_irq_enable <= WDATA[`BIT_DMA_IE];
                    irq_enable_other <= WDATA;
                end
                `OFF_RXEND_L: rx_buffer_end <= put_byte(rx_buffer_end, WDATA, 1'b0);
                `OFF_RXEND_H: rx_buffer_end <= put_byte(rx_buffer_end, WDATA, 1'b1);
                `OFF_RXSTART_L: rx_buffer_start <= put_byte(rx_buffer_start, WDATA, 1'b0);
                `OFF_RXSTART_H: rx_buffer_start <= put_byte(rx_buffer_start, WDATA, 1'b1);
                `OFF_SRCSTART_L: dma_source_start <= put_byte(dma_source_start, WDATA, 1'b0);
                `OFF_SRCSTART_H: dma_source_start <= put_byte(dma_source_start, WDATA, 1'b1);
                `OFF_SRCEND_L: dma_source_end <= put_byte(dma_source_end, WDATA, 1'b0);
                `OFF_SRCEND_H: dma_source_end <= put_byte(dma_source_end, WDATA, 1'b1);
                `OFF_DST_L: dma_dest_start <= put_byte(dma_dest_start, WDATA, 1'b0);
                `OFF_DST_H: dma_dest_start <= put_byte(dma_dest_start, WDATA, 1'b1);
                default: ;
            endcase
        end
    end

    // Read mux; other bits of shared registers read as stored except flag bit 7 (reads zero) and control bit 3 (TX_REQUEST_ACTIVE); unmapped reads zero
    always_ff @(posedge CLK)
    begin
        if (RST)
            RDATA <= 8'h00;
        else if (RD)
        begin
            unique case (ADDR)
                `OFF_IRQ_ENABLE: RDATA <= {global_irq_enable, irq_enable_other[6],
                                           dma_done_irq_enable, irq_enable_other[4:0]};
                `OFF_IRQ_FLAG: RDATA <= {1'b0, irq_flag_other[6], dma_done_flag,
                                         irq_flag_other[4:0]};
                `OFF_CONTROL_ONE: RDATA <= {control_other[7:6], dma_go_busy, checksum_select,
                                            TX_REQUEST_ACTIVE, control_other[2:0]};
                `OFF_RXEND_L: RDATA <= rx_buffer_end[7:0];
                `OFF_RXEND_H: RDATA <= {3'h0, rx_buffer_end[12:8]};
                `OFF_RXSTART_L: RDATA <= rx_buffer_start[7:0];
                `OFF_RXSTART_H: RDATA <= {3'h0, rx_buffer_start[12:8]};
                `OFF_SRCSTART_L: RDATA <= dma_source_start[7:0];
                `OFF_SRCSTART_H: RDATA <= {3'h0, dma_source_start[12:8]};
                `OFF_SRCEND_L: RDATA <= dma_source_end[7:0];
                `OFF_SRCEND_H: RDATA <= {3'h0, dma_source_end[12:8]};
                `OFF_DST_L: RDATA <= dma_dest_start[7:0];
                `OFF_DST_H: RDATA <= {3'h0, dma_dest_start[12:8]};
                `OFF_CSUM_L: RDATA <= dma_checksum_result[7:0];
                `OFF_CSUM_H: RDATA <= dma_checksum_result[15:8];
                default: RDATA <= 8'h00;
            endcase
        end
        else
            RDATA <= 8'h00;
    end

    // Active-low interrupt while done flag and both enables are set
    always_ff @(posedge CLK)
    begin
        if (RST)
            INT_N <= 1'b1;
        else
            INT_N <= !(dma_done_flag && dma_done_irq_enable && global_irq_enable);
    end
endmodule

// *** verification/dma_copy_properties.sv ***
// Port-level checker for the buffer DMA engine
`include "dma_copy_defines.svh"
module dma_copy_properties (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [4:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic TX_REQUEST_ACTIVE,
    input wire logic [12:0] MEM_ADDR,
    input wire logic MEM_RD,
    input wire logic MEM_WR,
    input wire logic [7:0] MEM_WDATA,
    input wire logic [7:0] MEM_RDATA,
    input wire logic INT_N
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    logic irq_reg_wr;
    // Only host writes to the enable or flag register may release the interrupt line
    assign irq_reg_wr = WR && (ADDR == `OFF_IRQ_ENABLE || ADDR == `OFF_IRQ_FLAG);
    // Host steps on the control register
    sequence s_ctrl_wr;
        WR && ADDR == `OFF_CONTROL_ONE;
    endsequence
    sequence s_copy_go_tx;
        s_ctrl_wr ##0 (WDATA[5] && !WDATA[4] && TX_REQUEST_ACTIVE);
    endsequence
    property p_wr_spacing;
        MEM_WR |=> !MEM_WR;
    endproperty
    a_wr_spacing: assert property (p_wr_spacing) else $error("copy writes too close");
    property p_dst_step;
        MEM_WR ##2 MEM_WR |-> MEM_ADDR == $past(MEM_ADDR, 2) + 13'h0001;
    endproperty
    a_dst_step: assert property (p_dst_step) else $error("destination not linear");
    property p_copy_data;
        MEM_WR |-> MEM_WDATA == $past(MEM_RDATA);
    endproperty
    a_copy_data: assert property (p_copy_data) else $error("copied byte differs");
    property p_abort_quiet;
        s_ctrl_wr ##0 !WDATA[5] |=> ##1 !MEM_WR [*4];
    endproperty
    a_abort_quiet: assert property (p_abort_quiet) else $error("write after abort");
    property p_tx_hold;
        s_copy_go_tx ##1 TX_REQUEST_ACTIVE [*5] |-> !MEM_WR && !$past(MEM_WR);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("copy during transmit");
    property p_csum_no_write;
        s_ctrl_wr ##0 (WDATA[5] && WDATA[4]) |=> !MEM_WR [*8];
    endproperty
    a_csum_no_write: assert property (p_csum_no_write) else $error("checksum wrote");
    property p_irq_off;
        WR && ADDR == `OFF_IRQ_ENABLE && !WDATA[7] |=> ##1 INT_N;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");
    property p_irq_hold;
        $rose(INT_N) |-> $past(irq_reg_wr, 2);
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped alone");
endmodule
bind buffer_dma_copy_checksum dma_copy_properties i_props (.CLK(CLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TX_REQUEST_ACTIVE(TX_REQUEST_ACTIVE),
    .MEM_ADDR(MEM_ADDR), .MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .MEM_WDATA(MEM_WDATA),
    .MEM_RDATA(MEM_RDATA), .INT_N(INT_N));

// *** verification/buffer_mem_model.sv ***
// Behavioural 8-Kbyte packet buffer behind the engine's memory port
module buffer_mem_model (
    input wire logic clk,
    input wire logic [12:0] addr,
    input wire logic wr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:8191];
    // Whole buffer starts cleared so unknowns never reach a checksum
    initial
    begin
        for (int i = 0; i < 8192; i++)
            mem[i] = 8'h00;
    end
    // Read follows the address in the same cycle, as the engine expects
    assign rdata = mem[addr];
    // Write lands on the edge that samples the strobe
    always @(posedge clk)
    begin
        if (wr)
            mem[addr] <= wdata;
    end
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the buffer DMA engine
`include "dma_copy_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, wr_s, rd_s, tx_req, mem_rd, mem_wr, int_n;
    logic [4:0] addr;
    logic [7:0] wdata, rdata, mem_wdata, mem_rdata, v, w;
    logic [12:0] mem_addr;
    int bad_count, samples_checked, wr_seen, base;

    buffer_dma_copy_checksum i_dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
        .WR(wr_s), .RD(rd_s), .RDATA(rdata), .TX_REQUEST_ACTIVE(tx_req), .MEM_ADDR(mem_addr),
        .MEM_RD(mem_rd), .MEM_WR(mem_wr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata),
        .INT_N(int_n));
    buffer_mem_model i_mem (.clk(clk), .addr(mem_addr), .wr(mem_wr), .wdata(mem_wdata),
        .rdata(mem_rdata));

    // 20 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Count buffer writes; blocking so the main flow reads it off the edge
    always @(posedge clk)
    begin
        if (mem_wr === 1'b1)
            wr_seen++;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One-cycle write strobe, released on the following edge
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic setp(input logic [4:0] lo, input logic [12:0] p);
        wr(lo, p[7:0]);
        wr(lo + 5'h01, {3'b000, p[12:8]});
    endtask
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic mark;
        @(negedge clk);
        base = wr_seen;
    endtask
    // Poll busy under a bound; a hang goes straight to the verdict
    task automatic wait_done(input int limit);
        logic [7:0] c;
        for (int n = 0; n < limit; n++)
        begin
            rd(`OFF_CONTROL_ONE, c);
            if (c[5] === 1'b0)
                return;
        end
        bad_count++;
        $display("unexpected at %0t: seen %h expected %h", $time, c, 8'h00);
        tally_and_finish();
    endtask
    task automatic ptrs(input logic [12:0] s, input logic [12:0] e, input logic [12:0] d);
        setp(`OFF_SRCSTART_L, s);
        setp(`OFF_SRCEND_L, e);
        setp(`OFF_DST_L, d);
    endtask

    initial
    begin
        {rst, wr_s, rd_s, tx_req, addr, wdata} = {1'b1, 3'b000, 5'h00, 8'h00};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // Registers: reset value, five-bit high byte, unmapped place
        rd(`OFF_SRCSTART_H, v);
        check(v, 8'h00);
        wr(`OFF_SRCSTART_H, 8'hFF);
        rd(`OFF_SRCSTART_H, v);
        check(v, 8'h1F);
        rd(5'h1F, v);
        check(v, 8'h00);
        $display("test registers done");
        // Copy across the top of the buffer, started while a transmit holds the port
        for (int i = 0; i < 4; i++)
            i_mem.mem[16 + i] = 8'hC1 + 8'(i);
        setp(`OFF_RXEND_L, 13'h1FFF);
        setp(`OFF_RXSTART_L, 13'h0000);
        ptrs(13'h0010, 13'h0013, 13'h1FFE);
        wr(`OFF_IRQ_FLAG, 8'h00);
        wr(`OFF_IRQ_ENABLE, 8'hA0);
        mark();
        tx_req <= 1'b1;
        wr(`OFF_CONTROL_ONE, 8'h20);
        repeat (10) @(posedge clk);
        rd(`OFF_CONTROL_ONE, v);
        check(v[5], 1'b1);
        check(16'(wr_seen - base), 16'h0000);
        tx_req <= 1'b0;
        wait_done(40);
        check(16'(wr_seen - base), 16'h0004);
        check({i_mem.mem[13'h1FFE], i_mem.mem[13'h1FFF]}, 16'hC1C2);
        check({i_mem.mem[13'h0000], i_mem.mem[13'h0001]}, 16'hC3C4);
        rd(`OFF_IRQ_FLAG, v);
        check(v[5], 1'b1);
        check(int_n, 1'b0);
        rd(`OFF_SRCSTART_L, v);
        check(v, 8'h10);
        wr(`OFF_IRQ_ENABLE, 8'h20);
        settle();
        check(int_n, 1'b1);
        wr(`OFF_IRQ_ENABLE, 8'hA0);
        settle();
        check(int_n, 1'b0);
        wr(`OFF_IRQ_FLAG, 8'h00);
        settle();
        check(int_n, 1'b1);
        $display("test copy done");
        // Checksum over an odd count, then over a wrapped receive ring
        {i_mem.mem[256], i_mem.mem[257], i_mem.mem[258]} = 24'h89ABCD;
        {i_mem.mem[512], i_mem.mem[513]} = 16'h1234;
        for (int k = 0; k < 2; k++)
        begin
            if (k == 0)
                ptrs(13'h0100, 13'h0102, 13'h0000);
            else
            begin
                setp(`OFF_RXSTART_L, 13'h0200);
                setp(`OFF_RXEND_L, 13'h0201);
                ptrs(13'h0201, 13'h0200, 13'h0000);
            end
            mark();
            wr(`OFF_CONTROL_ONE, 8'h30);
            wait_done(40);
            rd(`OFF_CSUM_H, v);
            rd(`OFF_CSUM_L, w);
            check({v, w}, (k == 0) ? 16'hA953 : 16'hCBED);
            check(16'(wr_seen - base), 16'h0000);
            rd(`OFF_IRQ_FLAG, v);
            check(v[5], 1'b1);
            wr(`OFF_IRQ_FLAG, 8'h00);
        end
        $display("test checksum done");
        // Equal start and end sweeps the buffer until the host aborts
        setp(`OFF_RXEND_L, 13'h1FFF);
        setp(`OFF_RXSTART_L, 13'h0000);
        ptrs(13'h0300, 13'h0300, 13'h0300);
        mark();
        wr(`OFF_CONTROL_ONE, 8'h20);
        repeat (40) @(posedge clk);
        wr(`OFF_CONTROL_ONE, 8'h00);
        settle();
        check(16'(wr_seen - base > 5), 16'h0001);
        rd(`OFF_CONTROL_ONE, v);
        check(v[5], 1'b0);
        rd(`OFF_IRQ_FLAG, v);
        check(v[5], 1'b1);
        rd(`OFF_DST_L, v);
        check(v, 8'h00);
        $display("test abort done");
        tally_and_finish();
    end
endmodule
